/* rtl/thr_defs.svh */
`ifndef THR_DEFS_SVH
`define THR_DEFS_SVH

// ==========================================================
// register addresses
`define ADR_LOW_HI 8'h8a
`define ADR_LOW_LO 8'h8b
`define ADR_HIGH_HI 8'h8c
`define ADR_HIGH_LO 8'h8d
`define ADR_STATUS 8'h8e
`define ADR_MOD 8'h8f
`define ADR_AMB_IR 8'h90

// ==========================================================
// reset values
`define MOD_RESET 8'h01
`define THR_RESET 16'h0000
`define PTR_RESET 8'h00
`define STATUS_RESET 4'h0
`define BYTE_ZERO 8'h00
`define CNT_RESET 8'h00
`define CNT_ONE 8'h01

// ==========================================================
// field positions
`define ST_PROX 3
`define ST_ALS 2
`define ST_LOW 1
`define ST_HIGH 0
`define DELAY_MSB 7
`define DELAY_LSB 5
`define FREQ_MSB 4
`define FREQ_LSB 3
`define DEAD_MSB 2
`define DEAD_LSB 0

`endif

/* rtl/thr_pkg.sv */
package thr_pkg;

  typedef struct packed {
    logic [7:0] ptr;
    logic [15:0] low_thr;
    logic [15:0] high_thr;
    logic [3:0] status;
    logic [7:0] mod_timing;
    logic [7:0] rd_data;
    logic rd_valid;
    logic int_n;
  } regs_t;

  typedef struct packed {
    logic [7:0] run;
    logic hit;
  } cmp_state_t;

endpackage

/* rtl/limit_if.sv */
`timescale 1ns/10ps
interface limit_if;
  logic valid;
  logic [15:0] sample;
  logic [15:0] limit;
  logic [7:0] need;
  logic hit;

  modport cmp (
    input valid,
    input sample,
    input limit,
    input need,
    output hit
  );

  modport src (
    output valid,
    output sample,
    output limit,
    output need,
    input hit
  );
endinterface

/* rtl/limit_compare.sv */
`timescale 1ns/10ps
`include "thr_defs.svh"
module limit_compare #(
  parameter bit ABOVE = 1'b0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // comparison channel
  limit_if.cmp lim
);

  thr_pkg::cmp_state_t s_q;
  thr_pkg::cmp_state_t s_d;
  logic qualifies;

  // ==========================================================
  // consecutive run counter
  always_comb begin
    qualifies = ABOVE ? (lim.sample > lim.limit) : (lim.sample < lim.limit);
    s_d = s_q;
    s_d.hit = 1'b0;
    if (lim.valid) begin
      if (!qualifies) begin
        s_d.run = `CNT_RESET;
      end else if (s_q.run + `CNT_ONE >= lim.need) begin
        // restart the run so a steady level keeps firing every need samples
        s_d.run = `CNT_RESET;
        s_d.hit = 1'b1;
      end else begin
        s_d.run = s_q.run + `CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '{run: `CNT_RESET, hit: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign lim.hit = s_q.hit;

endmodule

/* rtl/threshold_interrupt_regs.sv */
`timescale 1ns/10ps
`include "thr_defs.svh"
module threshold_interrupt_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // serial bus byte layer
  input wire logic i_addr_valid,
  input wire logic [7:0] i_addr,
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_req,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  // interrupt control bits
  input wire logic i_limit_source_select,
  input wire logic i_limit_irq_enable,
  input wire logic i_prox_ready_irq_enable,
  input wire logic i_als_ready_irq_enable,
  input wire logic [2:0] i_count_exceed_code,
  // measurement results
  input wire logic i_prox_ready,
  input wire logic [15:0] i_prox_result,
  input wire logic i_als_ready,
  input wire logic [15:0] i_als_result,
  // interrupt pin
  output logic o_int_n,
  // modulator settings
  output logic [2:0] o_delay_time,
  output logic [1:0] o_prox_frequency,
  output logic [2:0] o_dead_time
);

  thr_pkg::regs_t r_q;
  thr_pkg::regs_t r_d;

  limit_if below_ch ();
  limit_if above_ch ();

  logic sel_valid;
  logic [15:0] sel_result;
  logic [7:0] need;
  logic [3:0] set_bits;
  logic [3:0] clr_bits;
  logic [7:0] rd_mux;
  logic take_addr;
  logic take_wr;
  logic take_rd;
  logic [7:0] ptr_next;
  logic wr_low_hi;
  logic wr_low_lo;
  logic wr_high_hi;
  logic wr_high_lo;
  logic wr_status;
  logic wr_mod;
  logic [15:0] low_next;
  logic [15:0] high_next;
  logic [7:0] mod_next;
  logic [3:0] status_next;
  logic irq_pending;

  // ==========================================================
  // result selection and comparators
  always_comb begin
    // the selected source alone feeds both comparators
    sel_valid = i_limit_source_select ? i_als_ready : i_prox_ready;
    sel_result = i_limit_source_select ? i_als_result : i_prox_result;
    // count code n asks for 2**n consecutive results
    need = `CNT_ONE << i_count_exceed_code;
  end

  assign below_ch.valid = sel_valid;
  assign below_ch.sample = sel_result;
  assign below_ch.limit = r_q.low_thr;
  assign below_ch.need = need;
  assign above_ch.valid = sel_valid;
  assign above_ch.sample = sel_result;
  assign above_ch.limit = r_q.high_thr;
  assign above_ch.need = need;

  limit_compare #(
    .ABOVE(1'b0)
  ) u_below (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .lim(below_ch.cmp)
  );

  limit_compare #(
    .ABOVE(1'b1)
  ) u_above (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .lim(above_ch.cmp)
  );

  // ==========================================================
  // event sources
  always_comb begin
    set_bits = `STATUS_RESET;
    set_bits[`ST_PROX] = i_prox_ready & i_prox_ready_irq_enable;
    set_bits[`ST_ALS] = i_als_ready & i_als_ready_irq_enable;
    set_bits[`ST_LOW] = below_ch.hit & i_limit_irq_enable;
    set_bits[`ST_HIGH] = above_ch.hit & i_limit_irq_enable;
  end

  // ==========================================================
  // request decode
  // one request per edge: address phase first, then write, then read
  always_comb begin
    take_addr = i_addr_valid;
    take_wr = !i_addr_valid && i_wr_valid;
    take_rd = !i_addr_valid && !i_wr_valid && i_rd_req;
    // the pointer wraps from ff to 00 on purpose
    ptr_next = 8'(r_q.ptr + `CNT_ONE);
  end

  // ==========================================================
  // write strobes
  // the reserved ambient IR place and unmapped addresses match no strobe,
  // so such writes vanish while the pointer still moves on
  always_comb begin
    wr_low_hi = take_wr && (r_q.ptr == `ADR_LOW_HI);
    wr_low_lo = take_wr && (r_q.ptr == `ADR_LOW_LO);
    wr_high_hi = take_wr && (r_q.ptr == `ADR_HIGH_HI);
    wr_high_lo = take_wr && (r_q.ptr == `ADR_HIGH_LO);
    wr_status = take_wr && (r_q.ptr == `ADR_STATUS);
    wr_mod = take_wr && (r_q.ptr == `ADR_MOD);
  end

  // ==========================================================
  // next stored values
  // each limit byte lands alone; a read between the two writes of a pair
  // sees half of the new value, the price of keeping no shadow copy
  always_comb begin
    low_next = r_q.low_thr;
    high_next = r_q.high_thr;
    mod_next = r_q.mod_timing;
    clr_bits = `STATUS_RESET;
    if (wr_low_hi) begin
      low_next[15:8] = i_wr_data;
    end
    if (wr_low_lo) begin
      low_next[7:0] = i_wr_data;
    end
    if (wr_high_hi) begin
      high_next[15:8] = i_wr_data;
    end
    if (wr_high_lo) begin
      high_next[7:0] = i_wr_data;
    end
    if (wr_status) begin
      clr_bits = i_wr_data[3:0];
    end
    if (wr_mod) begin
      mod_next = i_wr_data;
    end
  end

  // ==========================================================
  // sticky status
  // set wins over a same-cycle write-one clear, so an event that lands
  // between the host's read and its clear is never lost
  always_comb begin
    status_next = (r_q.status & ~clr_bits) | set_bits;
    irq_pending = |status_next;
  end

  // ==========================================================
  // read multiplexer
  always_comb begin
    unique case (r_q.ptr)
      `ADR_LOW_HI: rd_mux = r_q.low_thr[15:8];
      `ADR_LOW_LO: rd_mux = r_q.low_thr[7:0];
      `ADR_HIGH_HI: rd_mux = r_q.high_thr[15:8];
      `ADR_HIGH_LO: rd_mux = r_q.high_thr[7:0];
      `ADR_STATUS: rd_mux = {4'h0, r_q.status};
      `ADR_MOD: rd_mux = r_q.mod_timing;
      // reserved ambient IR level and unmapped addresses read zero
      default: rd_mux = `BYTE_ZERO;
    endcase
  end

  // ==========================================================
  // register update
  always_comb begin
    r_d = r_q;
    r_d.rd_valid = 1'b0;
    r_d.low_thr = low_next;
    r_d.high_thr = high_next;
    r_d.mod_timing = mod_next;
    r_d.status = status_next;
    r_d.int_n = ~irq_pending;
    if (take_addr) begin
      r_d.ptr = i_addr;
    end else if (take_wr || take_rd) begin
      // the pointer moves on after every byte, even a dropped write
      r_d.ptr = ptr_next;
    end
    if (take_rd) begin
      r_d.rd_data = rd_mux;
      r_d.rd_valid = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r_q <= '{
        ptr: `PTR_RESET,
        low_thr: `THR_RESET,
        high_thr: `THR_RESET,
        status: `STATUS_RESET,
        mod_timing: `MOD_RESET,
        rd_data: `BYTE_ZERO,
        rd_valid: 1'b0,
        int_n: 1'b1
      };
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // outputs, all straight from flops
  assign o_rd_data = r_q.rd_data;
  assign o_rd_valid = r_q.rd_valid;
  assign o_int_n = r_q.int_n;
  assign o_delay_time = r_q.mod_timing[`DELAY_MSB:`DELAY_LSB];
  assign o_prox_frequency = r_q.mod_timing[`FREQ_MSB:`FREQ_LSB];
  assign o_dead_time = r_q.mod_timing[`DEAD_MSB:`DEAD_LSB];

endmodule

/* bench/thr_chk_sva.sv */
`timescale 1ns/10ps
module thr_chk (
  // watched ports
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_addr_valid,
  input wire logic i_wr_valid,
  input wire logic i_rd_req,
  input wire logic i_limit_irq_enable,
  input wire logic i_prox_ready_irq_enable,
  input wire logic i_als_ready_irq_enable,
  input wire logic i_prox_ready,
  input wire logic i_als_ready,
  input wire logic o_rd_valid,
  input wire logic o_int_n,
  input wire logic [2:0] o_delay_time,
  input wire logic [1:0] o_prox_frequency,
  input wire logic [2:0] o_dead_time
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  logic go;
  logic off;
  assign go = i_rd_req && !i_addr_valid && !i_wr_valid;
  assign off = !i_limit_irq_enable && !i_prox_ready_irq_enable && !i_als_ready_irq_enable;
  // ==========================================================
  // assertions
  chk_rd_answer: assert property (go |=> o_rd_valid) else $error("no read");
  chk_rd_quiet: assert property (!go |=> !o_rd_valid) else $error("stray read");
  chk_prox_pin: assert property (i_prox_ready && i_prox_ready_irq_enable |=> !o_int_n)
    else $error("prox pin");
  chk_als_pin: assert property (i_als_ready && i_als_ready_irq_enable |=> !o_int_n)
    else $error("als pin");
  chk_int_sticky: assert property (!o_int_n && !i_wr_valid |=> !o_int_n)
    else $error("int dropped");
  chk_int_quiet: assert property (o_int_n && !i_prox_ready && !i_als_ready &&
    !$past(i_prox_ready) && !$past(i_als_ready) |=> o_int_n) else $error("int rose");
  chk_mod_hold: assert property (!i_wr_valid |=>
    $stable({o_delay_time, o_prox_frequency, o_dead_time})) else $error("mod moved");
  chk_off_quiet: assert property (off [*3] ##0 o_int_n |=> o_int_n)
    else $error("disabled int");
  cover property (o_rd_valid);
  cover property ($fell(o_int_n));
  cover property ($rose(o_int_n));
endmodule
bind threshold_interrupt_regs thr_chk u_chk (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_addr_valid(i_addr_valid), .i_wr_valid(i_wr_valid), .i_rd_req(i_rd_req),
  .i_limit_irq_enable(i_limit_irq_enable), .i_prox_ready_irq_enable(i_prox_ready_irq_enable),
  .i_als_ready_irq_enable(i_als_ready_irq_enable), .i_prox_ready(i_prox_ready),
  .i_als_ready(i_als_ready), .o_rd_valid(o_rd_valid), .o_int_n(o_int_n),
  .o_delay_time(o_delay_time), .o_prox_frequency(o_prox_frequency),
  .o_dead_time(o_dead_time));

/* bench/host_model.sv */
`timescale 1ns/10ps
module host_model (
  // clock
  input wire logic i_clk,
  // byte layer requests
  output logic o_av,
  output logic [7:0] o_a,
  output logic o_wv,
  output logic [7:0] o_wd,
  output logic o_rq
);
  initial {o_av, o_a, o_wv, o_wd, o_rq} = '0;
  // k: 0 address, 1 write, 2 read; the reserved ambient IR place is never addressed
  task pulse(int k, logic [7:0] v);
    @(posedge i_clk);
    o_av <= k == 0;
    o_wv <= k == 1;
    o_rq <= k == 2;
    o_a <= v;
    o_wd <= v;
    @(posedge i_clk);
    {o_av, o_wv, o_rq} <= '0;
    // inverted once released, so a stale byte never passes as fresh
    o_a <= ~v;
    o_wd <= ~v;
  endtask
endmodule

/* bench/threshold_interrupt_regs_tb.sv */
`timescale 1ns/10ps
module threshold_interrupt_regs_tb;
  logic i_clk = 0, i_nrst = 0, ps = 0, pe = 0, ae = 0, le = 0, pr = 0, ar = 0;
  logic [15:0] v_q = 0;
  logic [2:0] cc = 3'h0;
  logic av, wv, rq, rv, int_n;
  logic [7:0] a, wd, rd;
  logic [7:0] w[6];
  logic [2:0] dly, dead;
  logic [1:0] fq;
  logic [7:0] exp_q[$];
  int n_errors = 0, check_count = 0;
  logic [31:0] rnd = 32'h69b3_03ea;
  always #25 i_clk = ~i_clk;
  host_model host (.i_clk(i_clk), .o_av(av), .o_a(a), .o_wv(wv), .o_wd(wd), .o_rq(rq));
  threshold_interrupt_regs dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr_valid(av),
    .i_addr(a), .i_wr_valid(wv), .i_wr_data(wd), .i_rd_req(rq), .o_rd_data(rd),
    .o_rd_valid(rv), .i_limit_source_select(ps), .i_limit_irq_enable(le),
    .i_prox_ready_irq_enable(pe), .i_als_ready_irq_enable(ae), .i_count_exceed_code(cc),
    .i_prox_ready(pr), .i_prox_result(v_q), .i_als_ready(ar), .i_als_result(v_q),
    .o_int_n(int_n), .o_delay_time(dly), .o_prox_frequency(fq), .o_dead_time(dead));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmp(logic [7:0] g, logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rdx(logic [7:0] e);
    exp_q.push_back(e);
    host.pulse(2, 8'h00);
  endtask
  always @(posedge i_clk) if (rv) cmp(rd, exp_q.size() > 0 ? exp_q.pop_front() : ~rd);
  // c: select, prox enable, als enable, limit enable
  task scen(logic [3:0] c, logic p, logic [15:0] v, logic [7:0] e);
    @(posedge i_clk);
    {ps, pe, ae, le} <= c;
    @(posedge i_clk);
    pr <= p;
    ar <= !p;
    v_q <= v;
    @(posedge i_clk);
    {pr, ar} <= '0;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    cmp({7'h0, int_n}, {7'h0, e == 8'h00});
    host.pulse(0, 8'h8e);
    rdx(e);
    host.pulse(0, 8'h8e);
    host.pulse(1, e);
    @(negedge i_clk);
    cmp({7'h0, int_n}, 8'h01);
  endtask
  task test_done;
    // a read that never came back leaves its note behind
    cmp(8'(exp_q.size()), 8'h00);
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    // run needs under two hundred cycles; 20000 is ample
    #1000000;
    n_errors++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_nrst <= 1;
    host.pulse(0, 8'h8a);
    for (int i = 0; i < 6; i++) rdx(i == 5 ? 8'h01 : 8'h00);
    host.pulse(0, 8'h80);
    rdx(8'h00);
    $display("reset test done");
    rnd = lfsr(rnd);
    for (int f = 0; f < 4; f++) begin
      host.pulse(0, 8'h8f);
      host.pulse(1, {rnd[7:5], 2'(f), rnd[2:0]});
      @(negedge i_clk);
      cmp({dly, fq, dead}, {rnd[7:5], 2'(f), rnd[2:0]});
    end
    rnd = lfsr(rnd);
    // low kept above 7fff and high below 8000 so 0000 and ffff both cross
    w = '{rnd[7:0] | 8'h80, rnd[15:8], rnd[23:16] & 8'h7f, rnd[31:24], 8'h00, 8'h01};
    host.pulse(0, 8'h8a);
    for (int i = 0; i < 6; i++) host.pulse(1, w[i]);
    host.pulse(0, 8'h8a);
    for (int i = 0; i < 6; i++) rdx(w[i]);
    $display("register test done");
    scen(4'b0111, 1'b1, 16'h0000, 8'h0a);
    scen(4'b1011, 1'b0, 16'hffff, 8'h05);
    scen(4'b0110, 1'b1, 16'h0000, 8'h08);
    scen(4'b1001, 1'b1, 16'h0000, 8'h00);
    scen(4'b0000, 1'b0, 16'hffff, 8'h00);
    @(posedge i_clk);
    cc <= 3'h1;
    // two consecutive results are needed now, so only the second one flags
    scen(4'b0001, 1'b1, 16'h0000, 8'h00);
    scen(4'b0001, 1'b1, 16'h0000, 8'h02);
    $display("event test done");
    repeat (4) @(posedge i_clk);
    test_done;
  end
endmodule
